//--- design/synth_cfg_pkg.sv
// Shared constants for the synthesizer serial configuration link
package synth_cfg_pkg;
    localparam int CFG_BITS = 8;
    localparam int REF_BITS = 16;
    localparam int A_BITS = 24;
    localparam int DIV_W = 13;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] REF_MODE_RESET = 3'h6;
    localparam logic [12:0] REF_DIV_RESET = 13'h0001;
    localparam logic [1:0] OUTA_DATA_OUT = 2'h0;
    localparam logic [1:0] OUTA_PORT = 2'h3;
    localparam int POS_POL = 7;
    localparam int POS_SEL = 6;
    localparam int POS_LDE = 5;
    localparam int POS_STANDBY_REQUEST = 4;
    localparam int POS_IHI = 3;
    localparam int POS_ILO = 2;
    localparam int POS_PORT = 1;
    localparam int POS_OUTB = 0;
    localparam int POS_OUTA_LO = 22;
    localparam logic [2:0] MODE_REF_STATIC_LOW = 3'h2;
    localparam int CNT_W = 5;
    localparam int HOST_HALF = 2;
    localparam int FRAME_GAP = 2;
endpackage

//--- design/synth_link_if.sv
// Serial link between the host controller and the synthesizer registers
`timescale 1ns/1ps
interface synth_link_if;
    logic serial_clk;
    logic serial_data;
    logic serial_enable_n;
    logic data_out;
    modport device (input serial_clk, input serial_data, input serial_enable_n, output data_out);
    modport host (output serial_clk, output serial_data, output serial_enable_n, input data_out);
endinterface

//--- design/synth_host.sv
// Host side: shifts words out on the serial link on request
`timescale 1ns/1ps
module synth_host
    import synth_cfg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    synth_link_if.host link,
    input wire logic [1:0] ADDR,
    input wire logic [23:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA
);
    typedef enum logic [2:0] {IDLE, LOW, HIGH, FRAME_END, LOAD} state_t;
    typedef struct packed {
        state_t state;
        logic [23:0] shift;
        logic [CNT_W-1:0] bits;
        logic [1:0] half;
        logic busy;
        logic sclk;
        logic sdata;
        logic enb_n;
        logic [7:0] rdata;
    } host_t;
    host_t r, next_r;

    function automatic logic [CNT_W-1:0] frame_len(input logic [1:0] a);
        frame_len = (a == 2'h0) ? CNT_W'(CFG_BITS) : (a == 2'h1) ? CNT_W'(REF_BITS) : CNT_W'(A_BITS);
    endfunction

    assign link.serial_clk = r.sclk;
    assign link.serial_data = r.sdata;
    assign link.serial_enable_n = r.enb_n;
    assign RDATA = r.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer: enable low, MSB first, clock high to sample
    always_comb
    begin
        next_r = r;
        if (RD)
            next_r.rdata = {7'h00, r.busy};
        unique case (r.state)
            IDLE:
            begin
                if (WR && !r.busy)
                begin
                    next_r.busy = 1'b1;
                    next_r.half = 2'h0;
                    if (ADDR == 2'h3)
                    begin
                        next_r.state = LOAD;
                        next_r.sclk = 1'b0;
                    end
                    else
                    begin
                        next_r.bits = frame_len(ADDR);
                        next_r.shift = WDATA << (A_BITS - int'(frame_len(ADDR)));
                        next_r.enb_n = 1'b0;
                        next_r.state = LOW;
                    end
                end
            end
            LOW:
            begin
                next_r.sclk = 1'b0;
                next_r.sdata = r.shift[23];
                next_r.half = r.half + 2'h1;
                if (r.half == 2'(HOST_HALF - 1))
                begin
                    next_r.half = 2'h0;
                    next_r.state = HIGH;
                end
            end
            HIGH:
            begin
                next_r.sclk = 1'b1;
                next_r.half = r.half + 2'h1;
                if (r.half == 2'(HOST_HALF - 1))
                begin
                    next_r.half = 2'h0;
                    next_r.shift = {r.shift[22:0], 1'b0};
                    next_r.bits = r.bits - CNT_W'(1);
                    next_r.state = (r.bits == CNT_W'(1)) ? FRAME_END : LOW;
                end
            end
            FRAME_END:
            begin
                next_r.sclk = 1'b0;
                next_r.enb_n = 1'b1;
                next_r.half = r.half + 2'h1;
                if (r.half == 2'(FRAME_GAP - 1))
                begin
                    next_r.busy = 1'b0;
                    next_r.state = IDLE;
                end
            end
            LOAD:
            begin
                // Pulse enable with the clock held low
                next_r.enb_n = (r.half == 2'h0) ? 1'b0 : 1'b1;
                next_r.half = r.half + 2'h1;
                if (r.half == 2'h2)
                begin
                    next_r.busy = 1'b0;
                    next_r.state = IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            r <= '{state: IDLE, shift: 24'h000000, bits: '0, half: 2'h0, busy: 1'b0,
                   sclk: 1'b0, sdata: 1'b0, enb_n: 1'b1, rdata: 8'h00};
        end
        else if (CLK_EN)
            r <= next_r;
    end
endmodule // synth_host

//--- design/synth_config_regs.sv
// Device side: serial configuration, reference divider and standby sequencing
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Eight-bit frame loads only the configuration register
// - Polarity bit inverts and swaps detector outputs
// - Select bit picks single or double detector
// - Lock enable bit, else lock forced low
// - Standby floats pump, parks pair, stops counters
// - Standby lock level follows lock enable bit
// - Standby keeps registers and both port outputs
// - Static-low reference mode gates input in standby
// - Standby exit first enables counters, parks double detector
// - First feedback pulse jam-loads, then detectors run
// - Bits three and two set pump current
// - Port bit drives output A as port
// - Port bit picks 10 or 25 percent steps
// - Output B bit floats or pulls low
// - Output A powers up as data out
// - Host keeps N at least A
// - A frame copies reference first buffer forward
// - Sixteen-bit frame: mode now, divider buffered
// - Bare enable pulse copies divider to active
// - Host programs divide 1 or 5 to 8191
// - Top three reference bits choose reference mode
// - Reference output powers up divided by eight
module synth_config_regs
    import synth_cfg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    synth_link_if.device link,
    input wire logic REF_DIV_PULSE,
    input wire logic FB_DIV_PULSE,
    input wire logic DET_UP,
    input wire logic DET_DOWN,
    input wire logic LOCK_RAW,
    output logic PUMP_OUT,
    output logic PUMP_OE_N,
    output logic [1:0] PUMP_CURRENT,
    output logic PUMP_STEP_25,
    output logic PUMP_BIAS_ON,
    output logic PHASE_R,
    output logic PHASE_V,
    output logic LOCK_OUT,
    output logic OUT_A,
    output logic OUT_B,
    output logic OUT_B_OE_N,
    output logic COUNT_EN,
    output logic JAM_LOAD,
    output logic [2:0] REF_MODE,
    output logic REF_INPUT_EN,
    output logic [12:0] REF_DIV_ACTIVE,
    output logic [23:0] A_WORD
);
    typedef enum logic [1:0] {RUN, STANDBY, WAIT_FB} power_t;
    typedef struct packed {
        logic sclk_d;
        logic enb_d;
        logic [23:0] shift;
        logic [CNT_W-1:0] count;
        logic [7:0] cfg;
        logic [2:0] ref_mode;
        logic [12:0] ref_buf1;
        logic [12:0] ref_buf2;
        logic [23:0] a_reg;
        power_t power;
        logic pump;
        logic pump_oe_n;
        logic phase_r;
        logic phase_v;
        logic lock;
        logic out_a;
        logic step25;
        logic jam;
        logic run_en;
        logic ref_en;
    } dev_t;
    dev_t r, next_r;
    logic detect_on;

    function automatic logic is_port(input logic [23:0] a);
        is_port = (a[POS_OUTA_LO+1:POS_OUTA_LO] == OUTA_PORT);
    endfunction

    assign link.data_out = r.shift[23];
    assign PUMP_OUT = r.pump;
    assign PUMP_OE_N = r.pump_oe_n;
    assign PUMP_CURRENT = r.cfg[POS_IHI:POS_ILO];
    assign PUMP_STEP_25 = r.step25;
    assign PUMP_BIAS_ON = r.run_en;
    assign PHASE_R = r.phase_r;
    assign PHASE_V = r.phase_v;
    assign LOCK_OUT = r.lock;
    assign OUT_A = r.out_a;
    // Open-drain output B only ever pulls low; its enable decides the level
    assign OUT_B = 1'b0;
    assign OUT_B_OE_N = r.cfg[POS_OUTB];
    assign COUNT_EN = r.run_en;
    assign JAM_LOAD = r.jam;
    assign REF_MODE = r.ref_mode;
    assign REF_INPUT_EN = r.ref_en;
    assign REF_DIV_ACTIVE = r.ref_buf2;
    assign A_WORD = r.a_reg;
    // Double detector only sees pulses once the standby exit has finished
    assign detect_on = (r.power == RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Serial capture, register loads, standby and output shaping
    always_comb
    begin
        next_r = r;
        next_r.sclk_d = link.serial_clk;
        next_r.enb_d = link.serial_enable_n;
        next_r.jam = 1'b0;
        // Shift on the serial clock rising edge while enabled
        if (!link.serial_enable_n && link.serial_clk && !r.sclk_d)
        begin
            next_r.shift = {r.shift[22:0], link.serial_data};
            if (r.count != CNT_W'(A_BITS))
                next_r.count = r.count + CNT_W'(1);
        end
        // Enable rising edge commits by bit count
        if (link.serial_enable_n && !r.enb_d)
        begin
            next_r.count = '0;
            if (r.count == CNT_W'(CFG_BITS))
                next_r.cfg = r.shift[7:0];
            else if (r.count == CNT_W'(REF_BITS))
            begin
                next_r.ref_mode = r.shift[15:13];
                next_r.ref_buf1 = r.shift[12:0];
            end
            else if (r.count == CNT_W'(A_BITS))
            begin
                next_r.a_reg = r.shift;
                next_r.ref_buf2 = r.ref_buf1;
            end
            else if (r.count == '0)
                next_r.ref_buf2 = r.ref_buf1;
        end
        // Standby entry and two-step exit
        unique case (r.power)
            RUN:
                if (r.cfg[POS_STANDBY_REQUEST])
                    next_r.power = STANDBY;
            STANDBY:
                if (!r.cfg[POS_STANDBY_REQUEST])
                    next_r.power = WAIT_FB;
            // Double detector stays parked until the first feedback pulse realigns the counters
            WAIT_FB:
                if (r.cfg[POS_STANDBY_REQUEST])
                    next_r.power = STANDBY;
                else if (FB_DIV_PULSE)
                begin
                    next_r.jam = 1'b1;
                    next_r.power = RUN;
                end
        endcase
        // Bias, counters and reference gate follow the next power state, so outputs stay on flops
        next_r.run_en = (next_r.power != STANDBY);
        next_r.ref_en = !(next_r.power == STANDBY && next_r.ref_mode == MODE_REF_STATIC_LOW);
        // Pump output: polarity and selection, floated in standby
        next_r.pump = DET_UP ^ r.cfg[POS_POL];
        next_r.pump_oe_n = !(r.cfg[POS_SEL] && r.power != STANDBY && (DET_UP || DET_DOWN));
        next_r.phase_r = 1'b1;
        next_r.phase_v = 1'b1;
        if (!r.cfg[POS_SEL] && detect_on)
        begin
            next_r.phase_r = r.cfg[POS_POL] ? !DET_UP : !DET_DOWN;
            next_r.phase_v = r.cfg[POS_POL] ? !DET_DOWN : !DET_UP;
        end
        if (!r.cfg[POS_LDE])
            next_r.lock = 1'b0;
        else if (r.power == STANDBY)
            next_r.lock = 1'b1;
        else
            next_r.lock = detect_on ? LOCK_RAW : 1'b1;
        // Output A as port or step-size selection
        if (is_port(r.a_reg))
        begin
            next_r.out_a = r.cfg[POS_PORT];
            next_r.step25 = 1'b0;
        end
        else
        begin
            next_r.out_a = (r.a_reg[POS_OUTA_LO+1:POS_OUTA_LO] == OUTA_DATA_OUT) ? r.shift[23] : REF_DIV_PULSE;
            next_r.step25 = r.cfg[POS_PORT];
        end
    end

    // State register
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            r <= '{sclk_d: 1'b0, enb_d: 1'b1, shift: 24'h000000, count: '0, cfg: CFG_RESET,
                   ref_mode: REF_MODE_RESET, ref_buf1: REF_DIV_RESET, ref_buf2: REF_DIV_RESET,
                   a_reg: {OUTA_DATA_OUT, 22'h000000}, power: RUN, pump: 1'b0, pump_oe_n: 1'b1,
                   phase_r: 1'b1, phase_v: 1'b1, lock: 1'b0, out_a: 1'b0, step25: 1'b0,
                   jam: 1'b0, run_en: 1'b1,
                   ref_en: 1'b1};
        end
        else if (CLK_EN)
            r <= next_r;
    end
endmodule // synth_config_regs

//--- bench/synth_link_checker.sv
// Checker of the serial link between host and device
`timescale 1ns/1ps
module synth_link_checker
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic serial_enable_n,
    input wire logic data_out
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////
    // Framing and bit timing of the link
    a_idle_clk_low: assert property (serial_enable_n |-> !serial_clk)
        else $error("serial clock high outside a frame");
    a_high_two: assert property ($rose(serial_clk) |=> serial_clk ##1 !serial_clk)
        else $error("serial clock high phase not two cycles");
    a_low_two: assert property ($rose(serial_clk) |-> !$past(serial_clk, 2))
        else $error("serial clock low phase too short");
    a_fall_low: assert property ($fell(serial_clk) && !serial_enable_n |=> !serial_clk)
        else $error("serial clock low phase one cycle");
    a_frame_start: assert property ($fell(serial_enable_n) |-> !serial_clk ##1 !serial_clk)
        else $error("frame starts with clock high");
    a_data_steady: assert property (serial_clk |-> $stable(serial_data))
        else $error("serial data moved while clock high");
    a_frame_bound: assert property ($fell(serial_enable_n) |-> ##[1:110] $rose(serial_enable_n))
        else $error("frame too long");
    a_enable_hold: assert property (!serial_enable_n && serial_clk && !$past(serial_clk) |=> !serial_enable_n)
        else $error("enable released in high phase");
    // Main link scenarios
    c_frame: cover property ($rose(serial_enable_n));
    c_bare: cover property ($fell(serial_enable_n) ##[1:6] $rose(serial_enable_n));
    c_bit: cover property ($rose(serial_clk));
endmodule // synth_link_checker

//--- bench/test_synth_serial_config_regs.sv
// Testbench joining host and device over the serial link
`timescale 1ns/1ps
module test_synth_serial_config_regs;
    import synth_cfg_pkg::*;
    logic clock, sys_rst, wr_s, rd_s, ref_p, fb_p, up, dn, lk;
    logic [1:0] addr;
    logic [23:0] wdata;
    logic [7:0] rdata;
    logic pump_out, pump_oe_n, step25, bias, ph_r, ph_v, lock, out_a, out_b, outb_oe_n, cnt_en, jam, ref_en;
    logic [1:0] pcur;
    logic [2:0] mode;
    logic [12:0] div;
    logic [23:0] aword;
    logic [1:0] p0;
    int bad_count = 0;
    int n_checks = 0;
    int n_rise = 0;
    synth_link_if synth_link_if_i();
    synth_host synth_host_i(.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1), .link(synth_link_if_i),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
    synth_config_regs synth_config_regs_i(.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1),
        .link(synth_link_if_i), .REF_DIV_PULSE(ref_p), .FB_DIV_PULSE(fb_p), .DET_UP(up), .DET_DOWN(dn),
        .LOCK_RAW(lk), .PUMP_OUT(pump_out), .PUMP_OE_N(pump_oe_n), .PUMP_CURRENT(pcur),
        .PUMP_STEP_25(step25), .PUMP_BIAS_ON(bias), .PHASE_R(ph_r), .PHASE_V(ph_v), .LOCK_OUT(lock),
        .OUT_A(out_a), .OUT_B(out_b), .OUT_B_OE_N(outb_oe_n), .COUNT_EN(cnt_en), .JAM_LOAD(jam),
        .REF_MODE(mode), .REF_INPUT_EN(ref_en), .REF_DIV_ACTIVE(div), .A_WORD(aword));
    synth_link_checker synth_link_checker_i(.CLOCK(clock), .SYS_RST(sys_rst),
        .serial_clk(synth_link_if_i.serial_clk), .serial_data(synth_link_if_i.serial_data),
        .serial_enable_n(synth_link_if_i.serial_enable_n), .data_out(synth_link_if_i.data_out));
    ////////////////////////////////////////////////////////////////
    // Clock and serial clock edge counter
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge synth_link_if_i.serial_clk)
        n_rise++;
    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One frame through the host, polling busy under a bound
    task automatic wr(input logic [1:0] a, input logic [23:0] d);
        int i;
        n_rise = 0;
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
        for (i = 0; i < 100; i++)
        begin
            rd_s <= 1'b1;
            @(posedge clock);
            rd_s <= 1'b0;
            @(posedge clock);
            if (rdata[0] === 1'b0)
                break;
        end
        if (i == 100)
        begin
            bad_count++;
            finish_test();
        end
        repeat (4) @(posedge clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk("ref_mode", REF_MODE_RESET, mode);
        chk("out_a_fn", OUTA_DATA_OUT, aword[23:22]);
        chk("lock", 0, lock);
        chk("pump_oe_n", 1, pump_oe_n);
        chk("out_b_oe_n", 0, outb_oe_n);
        chk("out_b", 0, out_b);
    endtask
    task automatic t_config;
        wr(2'h0, 24'hED);
        chk("clocks", 8, n_rise);
        chk("current", 3, pcur);
        chk("pump_oe_n", 0, pump_oe_n);
        chk("pair", 3, {ph_r, ph_v});
        chk("lock", 1, lock);
        chk("out_b_oe_n", 1, outb_oe_n);
        chk("step25", 0, step25);
        chk("ref_mode", REF_MODE_RESET, mode);
        chk("pump", 0, pump_out);
        wr(2'h0, 24'h02);
        chk("step25", 1, step25);
        chk("lock", 0, lock);
        chk("pump_oe_n", 1, pump_oe_n);
        chk("pump", 1, pump_out);
        chk("pair", 2, {ph_r, ph_v});
        p0 = {ph_r, ph_v};
        wr(2'h0, 24'h80);
        chk("swap", {p0[0], p0[1]}, {ph_r, ph_v});
    endtask
    task automatic t_standby;
        int i;
        logic seen;
        wr(2'h0, 24'h30);
        chk("pump_oe_n", 1, pump_oe_n);
        chk("pair", 3, {ph_r, ph_v});
        chk("count_en", 0, cnt_en);
        chk("bias", 0, bias);
        chk("lock", 1, lock);
        wr(2'h0, 24'h11);
        chk("lock", 0, lock);
        chk("out_b_oe_n", 1, outb_oe_n);
        wr(2'h1, 24'h4005);
        chk("ref_in", 0, ref_en);
        wr(2'h1, 24'h6005);
        chk("ref_in", 1, ref_en);
        chk("div", 1, div);
        wr(2'h0, 24'h00);
        chk("count_en", 1, cnt_en);
        chk("bias", 1, bias);
        chk("pair", 3, {ph_r, ph_v});
        seen = 1'b0;
        @(posedge clock);
        fb_p <= 1'b1;
        // Jam pulse stands for one cycle after the edge that sees the feedback pulse
        for (i = 0; i < 8; i++)
        begin
            @(posedge clock);
            fb_p <= 1'b0;
            #1;
            seen = seen | jam;
        end
        chk("jam", 1, seen);
        chk("pair", 2, {ph_r, ph_v});
    endtask
    task automatic t_reference;
        for (int m = 0; m < 8; m++)
        begin
            wr(2'h1, {8'h00, m[2:0], 13'h0007});
            chk("ref_mode", m[2:0], mode);
            chk("div", 1, div);
        end
        wr(2'h3, 24'h0);
        chk("clocks", 0, n_rise);
        chk("div", 7, div);
        wr(2'h1, 24'hDFFF);
        chk("clocks", 16, n_rise);
        chk("div", 7, div);
        wr(2'h2, 24'hC01234);
        chk("clocks", 24, n_rise);
        chk("a_word", 24'hC01234, aword);
        chk("div", 24'h1FFF, div);
        chk("ref_mode", 6, mode);
        chk("out_a", 0, out_a);
        wr(2'h0, 24'h02);
        chk("out_a", 1, out_a);
        chk("step25", 0, step25);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        {wr_s, rd_s, ref_p, fb_p, dn, lk} = 6'h01;
        up = 1'b1;
        addr = 2'h0;
        wdata = 24'h0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        t_reset();
        t_config();
        t_standby();
        t_reference();
        finish_test();
    end
endmodule // test_synth_serial_config_regs
